// ===== verilog/ptrd_top.sv
// pulse train reference decoder with input filters and simulated encoder
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module ptrd_top
    import ptrd_pkg::*;
#(
    parameter int GEN_UNIT_CYCLES   = MS_CYCLES,
    parameter int PROBE_UNIT_CYCLES = US_CYCLES
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        fast_step_channel_i,
    input  wire logic        fast_direction_channel_i,
    input  wire logic [4:0]  general_inputs_one_to_five_i,
    input  wire logic        general_input_eight_i,
    input  wire logic        probe_input_a_i,
    input  wire logic        probe_input_b_i,
    output logic [7:0]       filtered_inputs_o,
    output logic [POS_W-1:0] reference_count_o,
    output logic             simulated_encoder_output_a_o,
    output logic             simulated_encoder_output_b_o
);
    ptrd_fmt_t         pulse_format_setting;
    logic              direction_invert_setting;
    logic              pulse_reference_mode;
    logic [4:0]        input_filter_time_setting;
    logic [6:0]        probe_filter_time_setting;
    logic [7:0]        input_polarity;
    logic [POS_W-1:0]  enc_target;
    logic [POS_W-1:0]  enc_pos;
    logic [1:0]        enc_phase;
    logic [$clog2(ENC_EDGE_CYCLES+1)-1:0] enc_gap;
    logic              clear_req;
    logic              bus_req;
    logic              bus_wr;
    logic [7:0]        raw_inputs;
    logic [7:0]        deb_inputs;
    logic              step_q;
    logic              dir_q;
    logic              step_prev;
    logic              dir_prev;
    logic              step_edge;
    logic              dir_edge;
    logic              count_up;
    logic              count_down;
    logic              next_up;
    logic              next_down;
    logic [4:0]        gen_steps;
    logic [6:0]        prb_steps;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i;

    // single wait state acknowledge, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req;
    end

    // configuration registers, byte 0 lane used for control
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pulse_format_setting      <= PTRD_FMT_QUAD;
            direction_invert_setting  <= 1'b0;
            pulse_reference_mode      <= 1'b0;
            input_filter_time_setting <= GEN_RESET;
            probe_filter_time_setting <= PRB_RESET;
            input_polarity            <= POL_RESET;
            enc_target                <= '0;
            clear_req                 <= 1'b0;
        end
        else
        begin
            clear_req <= 1'b0;
            if (bus_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0])
            begin
                pulse_format_setting     <= ptrd_fmt_t'(wb_dat_i[CTRL_FMT_LSB +: 2]);
                direction_invert_setting <= wb_dat_i[CTRL_INV_BIT];
                pulse_reference_mode     <= wb_dat_i[CTRL_MODE_BIT];
                clear_req                <= wb_dat_i[CTRL_CLR_BIT];
            end
            else if (bus_wr && wb_adr_i == ADDR_FILTER)
            begin
                if (wb_sel_i[0])
                    input_filter_time_setting <= wb_dat_i[FILT_GEN_LSB +: 5];
                if (wb_sel_i[1])
                    probe_filter_time_setting <= wb_dat_i[FILT_PROBE_LSB +: 7];
            end
            else if (bus_wr && wb_adr_i == ADDR_POLARITY && wb_sel_i[0])
            begin
                input_polarity <= wb_dat_i[7:0];
            end
            else if (bus_wr && wb_adr_i == ADDR_ENC_CMD)
            begin
                enc_target <= wb_dat_i;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= '0;
        else if (bus_req && !wb_we_i)
        begin
            if (wb_adr_i == ADDR_CTRL)
                wb_dat_o <= {28'h000_0000, pulse_reference_mode, direction_invert_setting,
                             pulse_format_setting};
            else if (wb_adr_i == ADDR_FILTER)
                wb_dat_o <= {17'h0_0000, probe_filter_time_setting, 3'h0, input_filter_time_setting};
            else if (wb_adr_i == ADDR_POLARITY)
                wb_dat_o <= {24'h00_0000, input_polarity};
            else if (wb_adr_i == ADDR_POSITION)
                wb_dat_o <= reference_count_o;
            else if (wb_adr_i == ADDR_INPUTS)
                wb_dat_o <= {24'h00_0000, filtered_inputs_o};
            else if (wb_adr_i == ADDR_ENC_CMD)
                wb_dat_o <= enc_target;
            else if (wb_adr_i == ADDR_ENC_POS)
                wb_dat_o <= enc_pos;
            else
                wb_dat_o <= '0;
        end
    end

    // bit order: 0..4 general one to five, 5 probe a, 6 probe b, 7 general eight
    assign raw_inputs = {general_input_eight_i, probe_input_b_i, probe_input_a_i,
                         general_inputs_one_to_five_i} ^ input_polarity;

    assign gen_steps = (input_filter_time_setting > 5'(GEN_FILT_MAX_MS))
                       ? 5'(GEN_FILT_MAX_MS) : input_filter_time_setting;
    assign prb_steps = (probe_filter_time_setting > 7'(PROBE_FILT_MAX_US))
                       ? 7'(PROBE_FILT_MAX_US) : probe_filter_time_setting;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_filt
            if (gi == 5 || gi == 6)
            begin : g_probe
                // fast probe filter in microsecond units
                ptrd_debounce #(
                    .UNIT_CYCLES (PROBE_UNIT_CYCLES),
                    .STEP_W      (7)
                ) u_deb (
                    .clk_i   (clk_i),
                    .rst_i   (rst_i),
                    .raw_i   (raw_inputs[gi]),
                    .steps_i (prb_steps),
                    .level_o (deb_inputs[gi])
                );
            end
            else
            begin : g_gen
                ptrd_debounce #(
                    .UNIT_CYCLES (GEN_UNIT_CYCLES),
                    .STEP_W      (5)
                ) u_deb (
                    .clk_i   (clk_i),
                    .rst_i   (rst_i),
                    .raw_i   (raw_inputs[gi]),
                    .steps_i (gen_steps),
                    .level_o (deb_inputs[gi])
                );
            end
        end
    endgenerate

    assign filtered_inputs_o = deb_inputs;

    // pins are taken as synchronous; one register stage for edge history
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step_q    <= 1'b0;
            dir_q     <= 1'b0;
            step_prev <= 1'b0;
            dir_prev  <= 1'b0;
        end
        else
        begin
            step_q    <= fast_step_channel_i;
            dir_q     <= fast_direction_channel_i;
            step_prev <= step_q;
            dir_prev  <= dir_q;
        end
    end

    assign step_edge = step_q ^ step_prev;
    assign dir_edge  = dir_q ^ dir_prev;

    // decode the three pulse formats into up and down counts; reserved gives none
    always_comb
    begin
        next_up   = 1'b0;
        next_down = 1'b0;
        case (pulse_format_setting)
            PTRD_FMT_QUAD:
            begin
                // 4x decode: a lagging step edge follows a leading direction edge
                if (step_edge && !dir_edge)
                begin
                    next_up   = (step_q == dir_q);
                    next_down = (step_q != dir_q);
                end
                else if (dir_edge && !step_edge)
                begin
                    next_up   = (step_q != dir_q);
                    next_down = (step_q == dir_q);
                end
            end
            PTRD_FMT_CWCCW:
            begin
                next_up   = step_q && !step_prev;
                next_down = dir_q && !dir_prev;
            end
            PTRD_FMT_PULSE_DIR:
            begin
                // direction level sampled with the rising step edge
                next_up   = step_q && !step_prev && !dir_q;
                next_down = step_q && !step_prev && dir_q;
            end
            default:
            begin
                next_up   = 1'b0;
                next_down = 1'b0;
            end
        endcase
    end

    // simultaneous up and down cancel; invert swaps the sense
    assign count_up   = pulse_reference_mode && (next_up && !next_down) != direction_invert_setting
                        && (next_up ^ next_down);
    assign count_down = pulse_reference_mode && (next_up ^ next_down) && !count_up;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_req)
            reference_count_o <= '0;
        else if (count_up)
            reference_count_o <= reference_count_o + 1'b1;
        else if (count_down)
            reference_count_o <= reference_count_o - 1'b1;
    end

    // simulated encoder: steps toward target, one edge per gap at most
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            enc_pos   <= '0;
            enc_phase <= 2'h0;
            enc_gap   <= '0;
        end
        else if (enc_gap != '0)
        begin
            enc_gap <= enc_gap - 1'b1;
        end
        else if (enc_pos != enc_target)
        begin
            enc_gap <= ($bits(enc_gap))'(ENC_EDGE_CYCLES - 1);
            if ($signed(enc_target - enc_pos) > 0)
            begin
                enc_pos   <= enc_pos + 1'b1;
                enc_phase <= enc_phase + 2'h1;
            end
            else
            begin
                enc_pos   <= enc_pos - 1'b1;
                enc_phase <= enc_phase - 2'h1;
            end
        end
    end

    // gray order of phase: each channel toggles every second edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            simulated_encoder_output_a_o <= 1'b0;
            simulated_encoder_output_b_o <= 1'b0;
        end
        else
        begin
            simulated_encoder_output_a_o <= enc_phase[1];
            simulated_encoder_output_b_o <= enc_phase[1] ^ enc_phase[0];
        end
    end
endmodule
`default_nettype wire

// ===== verilog/ptrd_pkg.sv
// constants and types for the pulse train reference decoder
package ptrd_pkg;
    localparam int CLK_HZ            = 50_000_000;
    localparam int MS_NS             = 1_000_000;
    localparam int US_NS             = 1_000;
    localparam int CLK_NS            = 1_000_000_000 / CLK_HZ;
    localparam int MS_CYCLES         = MS_NS / CLK_NS;
    localparam int US_CYCLES         = US_NS / CLK_NS;
    localparam int GEN_FILT_MAX_MS   = 20;
    localparam int PROBE_FILT_MAX_US = 100;
    localparam int ENC_CH_KHZ        = 800;
    localparam int ENC_QUAD_KHZ      = 3200;
    // shortest gap between encoder edges, quadruple rate
    localparam int ENC_EDGE_CYCLES   = CLK_HZ / (ENC_QUAD_KHZ * 1000);
    localparam int POS_W             = 32;

    localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
    localparam logic [31:0] ADDR_FILTER   = 32'h0000_0004;
    localparam logic [31:0] ADDR_POLARITY = 32'h0000_0008;
    localparam logic [31:0] ADDR_POSITION = 32'h0000_000c;
    localparam logic [31:0] ADDR_INPUTS   = 32'h0000_0010;
    localparam logic [31:0] ADDR_ENC_CMD  = 32'h0000_0014;
    localparam logic [31:0] ADDR_ENC_POS  = 32'h0000_0018;

    localparam int CTRL_FMT_LSB   = 0;
    localparam int CTRL_INV_BIT   = 2;
    localparam int CTRL_MODE_BIT  = 3;
    localparam int CTRL_CLR_BIT   = 4;
    localparam int FILT_GEN_LSB   = 0;
    localparam int FILT_PROBE_LSB = 8;

    localparam logic [1:0]  FMT_RESET  = 2'h0;
    localparam logic [4:0]  GEN_RESET  = 5'h00;
    localparam logic [6:0]  PRB_RESET  = 7'h00;
    localparam logic [7:0]  POL_RESET  = 8'h00;

    typedef enum logic [1:0] {
        PTRD_FMT_QUAD,
        PTRD_FMT_CWCCW,
        PTRD_FMT_PULSE_DIR,
        PTRD_FMT_RSVD
    } ptrd_fmt_t;
endpackage

// ===== verilog/ptrd_debounce.sv
// one debounced input with a run-time filter length
`timescale 1ns/10ps
`default_nettype none
module ptrd_debounce
    import ptrd_pkg::*;
#(
    parameter int UNIT_CYCLES = 50_000,
    parameter int STEP_W      = 7
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              raw_i,
    input  wire logic [STEP_W-1:0] steps_i,
    output logic                   level_o
);
    logic [$clog2(UNIT_CYCLES+1)-1:0] unit_cnt;
    logic [STEP_W-1:0]                 step_cnt;

    // filter: input must stay different from output for steps_i whole units
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unit_cnt <= '0;
            step_cnt <= '0;
            level_o  <= 1'b0;
        end
        else if (raw_i == level_o)
        begin
            unit_cnt <= '0;
            step_cnt <= '0;
        end
        else if (step_cnt >= steps_i)
        begin
            level_o  <= raw_i;
            unit_cnt <= '0;
            step_cnt <= '0;
        end
        else if (unit_cnt == ($bits(unit_cnt))'(UNIT_CYCLES - 1))
        begin
            unit_cnt <= '0;
            step_cnt <= step_cnt + 1'b1;
        end
        else
        begin
            unit_cnt <= unit_cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== verification/ptrd_top_asserts.sv
// port-level assertions for the pulse train reference decoder
`timescale 1ns/10ps
`default_nettype none
module ptrd_top_asserts
    import ptrd_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic             wb_ack_o,
    input wire logic             fast_step_channel_i,
    input wire logic             fast_direction_channel_i,
    input wire logic [POS_W-1:0] reference_count_o,
    input wire logic             simulated_encoder_output_a_o,
    input wire logic             simulated_encoder_output_b_o
);
    logic [7:0] hist;
    logic [1:0] enc_q;
    logic [1:0] enc;
    logic [7:0] gap;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign enc = {simulated_encoder_output_a_o, simulated_encoder_output_b_o};
    always_ff @(posedge clk_i)
    begin
        hist <= {hist[5:0], fast_step_channel_i, fast_direction_channel_i};
    end
    // gap saturates so a long idle never wraps into a short one
    always_ff @(posedge clk_i)
    begin
        enc_q <= rst_i ? 2'h0 : enc;
        gap   <= rst_i ? 8'hff : (enc_q != enc) ? 8'h00 : gap + {7'h00, gap != 8'hff};
    end
    a_ack_follows:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_caused:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_count_cause:
    assert property ($changed(reference_count_o) |-> hist[1:0] != hist[3:2] || hist[3:2] != hist[5:4]
        || hist[5:4] != hist[7:6] || $past(wb_we_i && wb_stb_i) || $past(wb_we_i && wb_stb_i, 2))
        else $error("count moved without pin edge");
    a_count_unit:
    assert property ($changed(reference_count_o) |-> reference_count_o == '0
        || (reference_count_o - $past(reference_count_o)) inside {32'h0000_0001, 32'hffff_ffff})
        else $error("count jumped");
    a_enc_gray:
    assert property ((enc_q ^ enc) != 2'h3) else $error("both encoder lines moved");
    a_enc_gap:
    assert property (enc_q != enc |-> gap >= 8'(ENC_EDGE_CYCLES - 1)) else $error("encoder edges too close");
    a_reset_zero:
    assert property ($past(rst_i) |-> reference_count_o == '0 && !wb_ack_o && enc == 2'h0)
        else $error("outputs not cleared by reset");
endmodule
bind ptrd_top ptrd_top_asserts u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .fast_step_channel_i(fast_step_channel_i),
    .fast_direction_channel_i(fast_direction_channel_i), .reference_count_o(reference_count_o),
    .simulated_encoder_output_a_o(simulated_encoder_output_a_o),
    .simulated_encoder_output_b_o(simulated_encoder_output_b_o)
);
`default_nettype wire

// ===== verification/ptrd_ctrl_model.sv
// behavioural pulse generator in place of the external controller
`timescale 1ns/10ps
`default_nettype none
module ptrd_ctrl_model
    import ptrd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [1:0] fmt_i,
    input  wire logic       neg_i,
    output logic            step_o,
    output logic            dir_o,
    output logic            busy_o
);
    logic [1:0] ph = 2'h0;
    initial
    begin
        step_o = 1'b0;
        dir_o  = 1'b0;
        busy_o = 1'b0;
    end
    // each level held two clocks, above the one-clock minimum
    always
    begin
        @(posedge clk_i);
        if (go_i)
        begin
            busy_o <= 1'b1;
            if (fmt_i == PTRD_FMT_QUAD)
            begin
                ph = neg_i ? ph - 2'h1 : ph + 2'h1;
                dir_o  <= ^ph;
                step_o <= ph[1];
            end
            else
            begin
                step_o <= 1'b0;
                dir_o  <= (fmt_i == PTRD_FMT_PULSE_DIR) && neg_i;
                repeat (2) @(posedge clk_i);
                dir_o  <= dir_o | (fmt_i == PTRD_FMT_CWCCW && neg_i);
                step_o <= !(fmt_i == PTRD_FMT_CWCCW && neg_i);
                repeat (2) @(posedge clk_i);
                step_o <= 1'b0;
                dir_o  <= dir_o & (fmt_i == PTRD_FMT_PULSE_DIR);
            end
            repeat (2) @(posedge clk_i);
            busy_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verification/ptrd_top_tb.sv
// self-checking bench for the pulse train reference decoder
`timescale 1ns/10ps
`default_nettype none
module ptrd_top_tb
    import ptrd_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] adr = 32'h0000_0000;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic [31:0] rdat;
    logic [31:0] cnt;
    logic [7:0]  filt;
    logic [4:0]  gen = 5'h00;
    logic [1:0]  fmt = 2'h0;
    logic        pa = 1'b0;
    logic        go = 1'b0;
    logic        neg = 1'b0;
    logic        ack, enc_a, enc_b, step, dir, busy;
    int          err_count = 0;
    int          n_checks = 0;
    always #10 clk_i = ~clk_i;
    ptrd_top #(.GEN_UNIT_CYCLES(10), .PROBE_UNIT_CYCLES(4)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fast_step_channel_i(step), .fast_direction_channel_i(dir),
        .general_inputs_one_to_five_i(gen), .general_input_eight_i(1'b0),
        .probe_input_a_i(pa), .probe_input_b_i(1'b0), .filtered_inputs_o(filt),
        .reference_count_o(cnt), .simulated_encoder_output_a_o(enc_a),
        .simulated_encoder_output_b_o(enc_b)
    );
    ptrd_ctrl_model plc (
        .clk_i(clk_i), .go_i(go), .fmt_i(fmt), .neg_i(neg), .step_o(step), .dir_o(dir), .busy_o(busy)
    );
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // classic cycle; data taken and request released at the rising edge that sees ack
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        sel <= 4'hf;
        adr <= a;
        dat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        if (ack !== 1'b1) err_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic move(input logic ng);
        neg <= ng;
        go  <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        while (busy) @(posedge clk_i);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_0000, rdat);
        repeat (4) move(1'b0);
        chk("count off", 32'h0000_0000, cnt);
        for (int f = 0; f < 3; f++)
        begin
            fmt <= 2'(f);
            bus(1'b1, ADDR_CTRL, 32'h0000_0018 | 32'(f));
            repeat (4) move(1'b0);
            bus(1'b0, ADDR_POSITION, 32'h0000_0000);
            chk("count up", 32'h0000_0004, rdat);
            repeat (6) move(1'b1);
            bus(1'b0, ADDR_POSITION, 32'h0000_0000);
            chk("count down", 32'hffff_fffe, rdat);
        end
        bus(1'b1, ADDR_CTRL, 32'h0000_001e);
        repeat (3) move(1'b0);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_000e, rdat);
        chk("inverted", 32'hffff_fffd, cnt);
        bus(1'b1, ADDR_POLARITY, 32'h0000_0080);
        bus(1'b1, ADDR_FILTER, 32'h0000_0503);
        repeat (40) @(posedge clk_i);
        gen <= 5'h1f;
        pa  <= 1'b1;
        repeat (17) @(negedge clk_i);
        chk("filt early", 32'h0000_0080, {24'h00_0000, filt});
        repeat (7) @(negedge clk_i);
        chk("filt probe", 32'h0000_00a0, {24'h00_0000, filt});
        repeat (12) @(negedge clk_i);
        chk("filt gen", 32'h0000_00bf, {24'h00_0000, filt});
        @(posedge clk_i);
        bus(1'b0, ADDR_INPUTS, 32'h0000_0000);
        chk("inputs", 32'h0000_00bf, rdat);
        bus(1'b1, ADDR_ENC_CMD, 32'h0000_0005);
        repeat (100) @(posedge clk_i);
        bus(1'b0, ADDR_ENC_POS, 32'h0000_0000);
        chk("enc pos", 32'h0000_0005, rdat);
        chk("enc ab", 32'h0000_0001, {30'h0000_0000, enc_a, enc_b});
        bus(1'b1, ADDR_ENC_CMD, 32'h0000_0000);
        repeat (100) @(posedge clk_i);
        bus(1'b0, ADDR_ENC_POS, 32'h0000_0000);
        chk("enc back", 32'h0000_0000, rdat);
        bus(1'b0, 32'h0000_0020, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rdat);
        summarize();
    end
endmodule
`default_nettype wire
